// File: rie_exc_unit.sv
// reset and interrupt exception unit: pins, flags, arbiter, sequencer
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module rie_exc_unit
  import rie_pkg::*;
#(
  parameter rie_prio_t PRIO_SEQ = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        chip_reset_input_n,
  input  wire logic        unmask_pin,
  input  wire logic [3:0]  ext_request_pins,
  input  wire logic [5:0]  wake_pins,
  input  wire logic        timer_a_req,
  input  wire logic        sleep_xfer_req,
  input  wire logic        instr_done,
  input  wire logic [15:0] cur_pc,
  input  wire logic [15:0] cur_sp,
  input  wire logic [7:0]  ccr_in,
  input  wire logic        ccr_restore_stb,
  input  wire logic [7:0]  ccr_restore_val,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             cpu_halt_r,
  output logic             mask_bit_r,
  output logic             mem_req_r,
  output logic             mem_we_r,
  output logic [15:0]      mem_addr_r,
  output logic [15:0]      mem_wdata_r,
  output logic             pc_load_r,
  output logic [15:0]      pc_value_r,
  output logic             sp_load_r,
  output logic [15:0]      sp_value_r,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  `include "rie_consts.svh"

  rie_reg_if rbus ();

  rie_state_t  state_r;
  logic        chip_rst;
  logic [7:0]  edge_one_r;
  logic [7:0]  edge_two_r;
  logic [7:0]  enable_one_r;
  logic [7:0]  flag_one_r;
  logic [5:0]  wake_flag_r;
  logic [3:0]  pmode_one_r;
  logic [5:0]  pmode_five_r;
  logic        unmask_pend_r;
  logic        boot_block_r;
  rie_src_t    take_src_r;
  logic        take_unmask_r;
  logic [15:0] save_pc_r;
  logic [7:0]  save_ccr_r;
  logic [15:0] save_sp_r;
  logic [10:0] hits;
  logic        wr_byte0;
  logic [6:0]  req_vec;
  logic        mask_any;
  rie_src_t    win_src;
  logic        unmask_go;
  logic        take;
  logic [15:0] vec_addr;

  // the pin is taken as synchronous; low synchronously clears the registers, flags, edge hits and sequencer, but not the captured context
  assign chip_rst = ~chip_reset_input_n;
  assign wr_byte0 = rbus.wr_stb & rbus.wr_strb[0];

  rie_axil_slv u_axil (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rbus          (rbus)
  );

  // hits: [0] unmaskable, [4:1] request pins, [10:5] wake pins
  rie_edge_det #(.N(11)) u_edges (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clr      (chip_rst),
    .pins     ({wake_pins, ext_request_pins, unmask_pin}),
    .rise_sel ({edge_two_r[5:0], edge_one_r[3:0], edge_one_r[`RIE_EDGE_UNMASK_BIT]}),
    .use_en   ({pmode_five_r, pmode_one_r, 1'b1}),
    .hit      (hits)
  );

  // plain configuration registers written from the bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edge_one_r   <= `RIE_RST_REG;
      edge_two_r   <= `RIE_RST_REG;
      enable_one_r <= `RIE_RST_REG;
      pmode_one_r  <= 4'h0;
      pmode_five_r <= 6'h00;
    end else if (chip_rst) begin
      edge_one_r   <= `RIE_RST_REG;
      edge_two_r   <= `RIE_RST_REG;
      enable_one_r <= `RIE_RST_REG;
      pmode_one_r  <= 4'h0;
      pmode_five_r <= 6'h00;
    end else if (wr_byte0) begin
      unique case (rbus.wr_addr)
        `RIE_OFF_EDGE_ONE:   edge_one_r   <= rbus.wr_data[7:0];
        `RIE_OFF_EDGE_TWO:   edge_two_r   <= {2'h0, rbus.wr_data[5:0]};
        `RIE_OFF_ENABLE_ONE: enable_one_r <= rbus.wr_data[7:0];
        `RIE_OFF_PMODE_ONE:  pmode_one_r  <= rbus.wr_data[3:0];
        `RIE_OFF_PMODE_FIVE: pmode_five_r <= rbus.wr_data[5:0];
        default: ;
      endcase
    end
  end

  // request flags: hardware set wins over a software write of zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_one_r  <= `RIE_RST_REG;
      wake_flag_r <= 6'h00;
    end else if (chip_rst) begin
      flag_one_r  <= `RIE_RST_REG;
      wake_flag_r <= 6'h00;
    end else begin
      flag_one_r[3:0] <= hits[4:1] | (flag_one_r[3:0] & ~(
                         {4{wr_byte0 && rbus.wr_addr == `RIE_OFF_FLAG_ONE}}
                         & ~rbus.wr_data[3:0]));
      flag_one_r[`RIE_FLG_TMRA_BIT] <= timer_a_req | (flag_one_r[`RIE_FLG_TMRA_BIT] & ~(
                         wr_byte0 && rbus.wr_addr == `RIE_OFF_FLAG_ONE
                         && !rbus.wr_data[`RIE_FLG_TMRA_BIT]));
      flag_one_r[`RIE_FLG_SLEEP_BIT] <= sleep_xfer_req | (flag_one_r[`RIE_FLG_SLEEP_BIT] & ~(
                         wr_byte0 && rbus.wr_addr == `RIE_OFF_FLAG_ONE
                         && !rbus.wr_data[`RIE_FLG_SLEEP_BIT]));
      flag_one_r[5:4] <= 2'h0;
      wake_flag_r <= hits[10:5] | (wake_flag_r & ~(
                     {6{wr_byte0 && rbus.wr_addr == `RIE_OFF_WAKE_FLAG}}
                     & ~rbus.wr_data[5:0]));
    end
  end

  // unmaskable latch has no software flag; acceptance consumes it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unmask_pend_r <= 1'b0;
    end else if (chip_rst) begin
      unmask_pend_r <= 1'b0;
    end else begin
      unmask_pend_r <= hits[0] | (unmask_pend_r & ~(take & unmask_go));
    end
  end

  // pending and enabled sources; index 4 is the shared wake source
  assign req_vec = {flag_one_r[`RIE_FLG_SLEEP_BIT] & enable_one_r[`RIE_EN_SLEEP_BIT],
                    flag_one_r[`RIE_FLG_TMRA_BIT] & enable_one_r[`RIE_EN_TMRA_BIT],
                    (|wake_flag_r) & enable_one_r[`RIE_EN_WAKE_BIT],
                    flag_one_r[3:0] & enable_one_r[3:0]};

  // fixed order from the parameter, entry zero is the strongest
  always_comb begin
    win_src  = 3'h0;
    mask_any = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      if (req_vec[PRIO_SEQ[i]]) begin
        win_src  = PRIO_SEQ[i];
        mask_any = 1'b1;
      end
    end
  end

  // unmaskable ignores the mask bit; nothing passes before the first instruction
  assign unmask_go = unmask_pend_r & ~boot_block_r;
  assign take = (state_r == RIE_ST_RUN) & instr_done
              & (unmask_go | (mask_any & ~mask_bit_r & ~boot_block_r));

  // vector address is vector number times two
  assign vec_addr = take_unmask_r ? (`RIE_VNUM_UNMASK << 1)
                  : ((`RIE_VNUM_SRC_BASE + {13'h0000, take_src_r}) << 1);

  // block all requests until the first instruction after reset completes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_block_r <= 1'b1;
    end else if (chip_rst || state_r == RIE_ST_BOOT) begin
      boot_block_r <= 1'b1;
    end else if (state_r == RIE_ST_RUN && instr_done) begin
      boot_block_r <= 1'b0;
    end
  end

  // mask bit: set at reset release and after stacking, restored on return
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_bit_r <= 1'b1;
    end else if (chip_rst) begin
      mask_bit_r <= 1'b1;
    end else if (state_r == RIE_ST_HOLD) begin
      mask_bit_r <= 1'b1;
    end else if (state_r == RIE_ST_PUSH_CCR && mem_ack) begin
      mask_bit_r <= 1'b1;
    end else if (ccr_restore_stb && state_r == RIE_ST_RUN) begin
      mask_bit_r <= ccr_restore_val[`RIE_CCR_MASK_BIT];
    end
  end

  // context captured at the instruction boundary of acceptance
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      take_src_r    <= 3'h0;
      take_unmask_r <= 1'b0;
      save_pc_r     <= 16'h0000;
      save_ccr_r    <= 8'h00;
      save_sp_r     <= 16'h0000;
    end else if (take) begin
      take_src_r    <= win_src;
      take_unmask_r <= unmask_go;
      save_pc_r     <= cur_pc;
      save_ccr_r    <= {mask_bit_r, ccr_in[6:0]};
      save_sp_r     <= cur_sp & `RIE_WORD_ALIGN;
    end
  end

  // sequencer with its memory port; requests hold until acknowledged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r     <= RIE_ST_HOLD;
      cpu_halt_r  <= 1'b1;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= 16'h0000;
      mem_wdata_r <= 16'h0000;
      pc_load_r   <= 1'b0;
      pc_value_r  <= 16'h0000;
      sp_load_r   <= 1'b0;
      sp_value_r  <= 16'h0000;
    end else if (chip_rst) begin
      state_r    <= RIE_ST_HOLD;
      cpu_halt_r <= 1'b1;
      mem_req_r  <= 1'b0;
      mem_we_r   <= 1'b0;
      pc_load_r  <= 1'b0;
      sp_load_r  <= 1'b0;
    end else begin
      pc_load_r <= 1'b0;
      sp_load_r <= 1'b0;
      unique case (state_r)
        RIE_ST_HOLD: begin
          state_r    <= RIE_ST_BOOT;
          mem_req_r  <= 1'b1;
          mem_we_r   <= 1'b0;
          mem_addr_r <= `RIE_RESET_VECTOR;
        end
        RIE_ST_BOOT: begin
          if (mem_ack) begin
            mem_req_r  <= 1'b0;
            pc_value_r <= mem_rdata;
            pc_load_r  <= 1'b1;
            cpu_halt_r <= 1'b0;
            state_r    <= RIE_ST_RUN;
          end
        end
        RIE_ST_RUN: begin
          if (take) begin
            cpu_halt_r  <= 1'b1;
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= (cur_sp - `RIE_STK_PC_OFS) & `RIE_WORD_ALIGN;
            mem_wdata_r <= cur_pc;
            state_r     <= RIE_ST_PUSH_PC;
          end
        end
        RIE_ST_PUSH_PC: begin
          if (mem_ack) begin
            mem_addr_r  <= (save_sp_r - `RIE_STK_CCR_OFS) & `RIE_WORD_ALIGN;
            mem_wdata_r <= {save_ccr_r, save_ccr_r};
            state_r     <= RIE_ST_PUSH_CCR;
          end
        end
        RIE_ST_PUSH_CCR: begin
          if (mem_ack) begin
            mem_we_r   <= 1'b0;
            mem_addr_r <= vec_addr;
            state_r    <= RIE_ST_FETCH;
          end
        end
        RIE_ST_FETCH: begin
          if (mem_ack) begin
            mem_req_r  <= 1'b0;
            pc_value_r <= mem_rdata;
            pc_load_r  <= 1'b1;
            sp_value_r <= save_sp_r - `RIE_STK_CCR_OFS;
            sp_load_r  <= 1'b1;
            cpu_halt_r <= 1'b0;
            state_r    <= RIE_ST_RUN;
          end
        end
      endcase
    end
  end

  // register read mux and address decode for the bus slave
  always_comb begin
    rbus.rd_ok   = 1'b1;
    rbus.rd_data = 32'h0000_0000;
    unique case (rbus.rd_addr)
      `RIE_OFF_EDGE_ONE:   rbus.rd_data[7:0] = edge_one_r;
      `RIE_OFF_EDGE_TWO:   rbus.rd_data[7:0] = edge_two_r;
      `RIE_OFF_ENABLE_ONE: rbus.rd_data[7:0] = enable_one_r;
      `RIE_OFF_FLAG_ONE:   rbus.rd_data[7:0] = flag_one_r;
      `RIE_OFF_WAKE_FLAG:  rbus.rd_data[7:0] = `RIE_WAKE_RSV_ONES | {2'h0, wake_flag_r};
      `RIE_OFF_PMODE_ONE:  rbus.rd_data[3:0] = pmode_one_r;
      `RIE_OFF_PMODE_FIVE: rbus.rd_data[5:0] = pmode_five_r;
      `RIE_OFF_STATUS:     rbus.rd_data[15:0] = {2'h0, state_r, take_unmask_r, take_src_r,
                                                 unmask_pend_r, boot_block_r, 1'b0, mask_bit_r};
      default:             rbus.rd_ok = 1'b0;
    endcase
  end

  // writes to the read-only status word or unmapped offsets are refused
  always_comb begin
    unique case (rbus.wr_addr)
      `RIE_OFF_EDGE_ONE, `RIE_OFF_EDGE_TWO, `RIE_OFF_ENABLE_ONE, `RIE_OFF_FLAG_ONE,
      `RIE_OFF_WAKE_FLAG, `RIE_OFF_PMODE_ONE, `RIE_OFF_PMODE_FIVE: rbus.wr_ok = 1'b1;
      default: rbus.wr_ok = 1'b0;
    endcase
  end
endmodule // rie_exc_unit

// File: rie_consts.svh
// constants for the reset and interrupt exception unit
`ifndef RIE_CONSTS_SVH
`define RIE_CONSTS_SVH

`define RIE_AW               8
// register byte offsets
`define RIE_OFF_EDGE_ONE     8'h00
`define RIE_OFF_EDGE_TWO     8'h04
`define RIE_OFF_ENABLE_ONE   8'h08
`define RIE_OFF_FLAG_ONE     8'h0C
`define RIE_OFF_WAKE_FLAG    8'h10
`define RIE_OFF_PMODE_ONE    8'h14
`define RIE_OFF_PMODE_FIVE   8'h18
`define RIE_OFF_STATUS       8'h1C
// field positions
`define RIE_EDGE_UNMASK_BIT  7
`define RIE_EN_WAKE_BIT      5
`define RIE_EN_TMRA_BIT      6
`define RIE_EN_SLEEP_BIT     7
`define RIE_FLG_TMRA_BIT     6
`define RIE_FLG_SLEEP_BIT    7
`define RIE_CCR_MASK_BIT     7
// reset values
`define RIE_RST_REG          8'h00
`define RIE_WAKE_RSV_ONES    8'hC0
`define RIE_RESET_VECTOR     16'h0000
// vector numbers; vector address is number times two
`define RIE_VNUM_UNMASK      16'h0007
`define RIE_VNUM_SRC_BASE    16'h0008
// stack layout below the current stack pointer
`define RIE_STK_PC_OFS       16'h0002
`define RIE_STK_CCR_OFS      16'h0004
`define RIE_WORD_ALIGN       16'hFFFE
// bus responses
`define RIE_RESP_OKAY        2'h0
`define RIE_RESP_SLVERR      2'h2

`endif

// File: rie_pkg.sv
// types shared by the reset and interrupt exception unit
package rie_pkg;
  typedef enum logic [5:0] {
    RIE_ST_HOLD     = 6'h01,
    RIE_ST_BOOT     = 6'h02,
    RIE_ST_RUN      = 6'h04,
    RIE_ST_PUSH_PC  = 6'h08,
    RIE_ST_PUSH_CCR = 6'h10,
    RIE_ST_FETCH    = 6'h20
  } rie_state_t;
  typedef logic [2:0]      rie_src_t;
  typedef logic [6:0][2:0] rie_prio_t;
endpackage

// File: rie_reg_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ns
interface rie_reg_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport slv  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface

// File: rie_edge_det.sv
// pin synchroniser and selectable edge detector, one slice per pin
`timescale 1ns/1ns
module rie_edge_det #(
  parameter int N = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic [N-1:0] pins,
  input  wire logic [N-1:0] rise_sel,
  input  wire logic [N-1:0] use_en,
  output logic      [N-1:0] hit
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // two flops before any look at the level, third for the edge
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= pins[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // one pulse per qualifying edge
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          hit[g] <= 1'b0;
        end else if (clr) begin
          hit[g] <= 1'b0;
        end else begin
          hit[g] <= use_en[g] & (rise_sel[g] ? (s2_r & ~s3_r) : (~s2_r & s3_r));
        end
      end
    end
  endgenerate
endmodule // rie_edge_det

// File: rie_axil_slv.sv
// axi4-lite slave front end for the exception unit registers
`timescale 1ns/1ns
module rie_axil_slv (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  rie_reg_if.slv           rbus
);
  `include "rie_consts.svh"
  logic        aw_full_r;
  logic        w_full_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  // write happens once both halves are held and the last answer is gone
  assign do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;

  assign rbus.wr_stb  = do_wr;
  assign rbus.wr_addr = awaddr_r;
  assign rbus.wr_data = wdata_r;
  assign rbus.wr_strb = wstrb_r;
  assign rbus.rd_addr = s_axi_araddr;

  // address half, taken independently of data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_full_r     <= 1'b0;
      awaddr_r      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
      s_axi_awready <= ~aw_hs & ~(aw_full_r & ~do_wr);
    end
  end

  // data half
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w_full_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_hs) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
      s_axi_wready <= ~w_hs & ~(w_full_r & ~do_wr);
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RIE_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rbus.wr_ok ? `RIE_RESP_OKAY : `RIE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RIE_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rbus.rd_ok ? rbus.rd_data : 32'h0000_0000;
        s_axi_rresp  <= rbus.rd_ok ? `RIE_RESP_OKAY : `RIE_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~ar_hs & ~(s_axi_rvalid & ~s_axi_rready);
    end
  end
endmodule // rie_axil_slv

// File: rie_exc_unit_sva.sv
// concurrent checks on the core side of the exception unit
`timescale 1ns/1ns
module rie_exc_unit_sva (
  input wire logic        clk_sys, rst, chip_reset_input_n, instr_done, mem_ack,
  input wire logic        cpu_halt_r, mask_bit_r, mem_req_r, mem_we_r, pc_load_r,
  input wire logic [15:0] cur_pc, cur_sp, mem_rdata, mem_addr_r, mem_wdata_r, pc_value_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // stacking begins when the write strobe rises; a vector read ends on its ack
  sequence s_stack_go; $rose(mem_we_r); endsequence
  sequence s_vec_ack; mem_req_r && !mem_we_r && mem_ack && chip_reset_input_n; endsequence
  a_boot_fetch: assert property ($past(rst) && chip_reset_input_n |=>
    mem_req_r && !mem_we_r && mem_addr_r == 16'h0000) else $error("no boot fetch");
  a_chip_hold: assert property (!chip_reset_input_n |=>
    cpu_halt_r && mask_bit_r && !mem_req_r && !pc_load_r) else $error("chip reset");
  a_word_align: assert property (mem_req_r |-> !mem_addr_r[0] && cpu_halt_r)
    else $error("odd or unhalted access");
  a_req_steady: assert property (mem_req_r && !mem_ack && chip_reset_input_n |=>
    mem_req_r && $stable(mem_addr_r) && $stable(mem_wdata_r)) else $error("req dropped");
  a_push_pc: assert property (s_stack_go |-> $past(instr_done) &&
    mem_wdata_r == $past(cur_pc) && mem_addr_r == (($past(cur_sp) - 16'h0002) & 16'hFFFE))
    else $error("bad pc push");
  a_push_ccr: assert property (mem_we_r && $past(mem_we_r) && $changed(mem_addr_r) |->
    mem_addr_r == $past(mem_addr_r) - 16'h0002) else $error("bad ccr push");
  a_mask_set: assert property ($fell(mem_we_r) && mem_req_r |-> mask_bit_r)
    else $error("mask not set");
  a_vec_load: assert property (s_vec_ack |=> pc_load_r &&
    pc_value_r == $past(mem_rdata) ##1 !pc_load_r) else $error("vector not loaded");
  a_resp_time: assert property (disable iff (rst || !chip_reset_input_n)
    s_stack_go |-> ##[3:36] pc_load_r) else $error("slow vector load");
endmodule // rie_exc_unit_sva
bind rie_exc_unit rie_exc_unit_sva u_sva (.*);

// File: rie_core_mdl.sv
// core and stack memory stand-in facing the exception unit
`timescale 1ns/1ns
module rie_core_mdl (
  input wire logic        clk_sys, rst, cpu_halt_r, mem_req_r, mem_we_r, pc_load_r,
  input wire logic [15:0] mem_addr_r, mem_wdata_r, pc_value_r,
  output logic            mem_ack, instr_done,
  output logic [15:0]     mem_rdata, cur_pc
);
  logic [15:0] mem [0:127];
  logic [2:0]  cnt;
  logic [1:0]  ph;
  // word k holds h0100 plus its own byte address
  initial for (int k = 0; k < 128; k++) mem[k] = 16'h0100 + 16'(2 * k);
  // address bit 2 picks a slow answer; idle data bus toggles so stale data never matches
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {cnt, ph, mem_ack, instr_done} <= '0;
      mem_rdata <= 16'h5A5A;
      cur_pc <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      ph <= cpu_halt_r ? 2'h0 : ph + 2'h1;
      instr_done <= !cpu_halt_r && ph == 2'h3;
      cur_pc <= pc_load_r ? pc_value_r : cur_pc + {14'h0, instr_done, 1'b0};
      if (mem_req_r && !mem_ack) begin
        cnt <= cnt + 3'h1;
        if (cnt >= {1'b0, mem_addr_r[2], mem_addr_r[2]}) begin
          cnt <= 3'h0;
          mem_ack <= 1'b1;
          mem_rdata <= mem[mem_addr_r[7:1]];
          if (mem_we_r) mem[mem_addr_r[7:1]] <= mem_wdata_r;
        end
      end
    end
  end
endmodule // rie_core_mdl

// File: test_rie_exc_unit.sv
// self-checking bench for the exception unit
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_rie_exc_unit;
  logic        clk_sys = 1'b0, rst = 1'b1, chip_reset_input_n = 1'b1, unmask_pin = 1'b0;
  logic        timer_a_req = 1'b0, sleep_xfer_req = 1'b0, ccr_restore_stb = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_bvalid;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid, s_axi_arready;
  logic        s_axi_awready, s_axi_wready, instr_done, mem_ack, cpu_halt_r, mask_bit_r;
  logic        mem_req_r, mem_we_r, pc_load_r, sp_load_r;
  logic [3:0]  ext_request_pins = 4'h4;
  logic [5:0]  wake_pins = 6'h00;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [15:0] cur_pc, mem_addr_r, mem_wdata_r, mem_rdata, pc_value_r, sp_value_r;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          miscompares = 0, tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  // odd stack pointer on purpose, the unit must align it
  rie_exc_unit dut (.cur_sp(16'h00F1), .ccr_in(8'h80), .ccr_restore_val(8'h00),
                    .s_axi_wstrb(4'hF), .*);
  rie_core_mdl mdl (.*);
  // both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge clk_sys);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // wait for the handler jump, bounded
  task automatic wpc(input logic [15:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pc_load_r && n < 400);
    `CHK(pc_load_r, 1'b1)
    `CHK(pc_value_r, e)
  endtask
  // return from handler with mask bit clear
  task automatic rel;
    ccr_restore_stb <= 1'b1;
    @(posedge clk_sys);
    ccr_restore_stb <= 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence: boot, pin flags, arbitration, chip reset
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wpc(16'h0100);
    rd(8'h1C); `CHK(d[0], 1'b1)
    rd(8'h10); `CHK(d, 32'h000000C0)
    rd(8'h20); `CHK(r, 2'h2)
    wr(8'h1C, 32'h00); `CHK(r, 2'h2)
    wr(8'h14, 32'h0F); `CHK(r, 2'h0)
    wr(8'h18, 32'h3F);
    wr(8'h00, 32'h8B);
    wr(8'h04, 32'h20);
    {ext_request_pins, wake_pins} <= {4'h1, 6'h20};
    repeat (6) @(posedge clk_sys);
    rd(8'h0C); `CHK(d, 32'h00000005)
    rd(8'h10); `CHK(d, 32'h000000E0)
    wr(8'h0C, 32'h04);
    rd(8'h0C); `CHK(d, 32'h00000004)
    $display("test flags done");
    wr(8'h08, 32'h24);
    repeat (8) @(posedge clk_sys);
    `CHK(cpu_halt_r, 1'b0)
    rel;
    wpc(16'h0114);
    `CHK(mask_bit_r, 1'b1)
    `CHK(sp_load_r, 1'b1)
    `CHK(sp_value_r, 16'h00EC)
    wr(8'h0C, 32'h00);
    rel;
    wpc(16'h0118);
    wr(8'h10, 32'h00);
    unmask_pin <= 1'b1;
    wpc(16'h010E);
    wr(8'h08, 32'hC0);
    {timer_a_req, sleep_xfer_req} <= 2'h3;
    @(posedge clk_sys);
    {timer_a_req, sleep_xfer_req} <= 2'h0;
    rel;
    wpc(16'h011A);
    wr(8'h0C, 32'h80);
    rel;
    wpc(16'h011C);
    $display("test arbitration done");
    chip_reset_input_n <= 1'b0;
    rd(8'h08); `CHK(d, 32'h00000000)
    rd(8'h0C); `CHK(d, 32'h00000000)
    repeat (10) @(posedge clk_sys);
    chip_reset_input_n <= 1'b1;
    wpc(16'h0100);
    $display("test chip reset done");
    end_sim;
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule // test_rie_exc_unit
